// file: logic/rrx_exec.sv
// Execution unit for the return-type instructions and rotate through carry.
// Assumes a classic Wishbone master on sys_clk; the instruction cycle is
// four sys_clk phases generated here.
//
// Function
// - Interrupt return with shadow restores W, flags, bank
// - Shadow bit clear leaves W, flags, bank
// - Literal return loads W, pops, two cycles
// - Subroutine return pops in Q4, two cycles
// - Subroutine return with shadow restores context
// - Subroutine return decode 0x0012/3, flags untouched unless s is set
// - Returns never touch upper or high latches
// - Rotate left through carry, updates C, N, Z
// - Interrupt return pops, sets one global enable
// - Interrupt return decodes from 0x0010/1
`timescale 1ns/1ps

module rrx_exec
  import rrx_pkg::*;
#(
  parameter int STACK_DEPTH = 31,
  parameter int FILE_BANKS = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Status
  output logic execBusy_q
);

  ////////////////////////////////////////////////////////////////////////
  // Derived sizes and checks
  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam int FILE_DEPTH = FILE_BANKS * 256;
  localparam int FA_W = $clog2(FILE_DEPTH);

  // The bank select register has four bits, so at most sixteen banks
  if (STACK_DEPTH < 1 || FILE_BANKS < 1 || FILE_BANKS > 16) begin : g_chk
    $error("rrx_exec: unsupported STACK_DEPTH or FILE_BANKS");
  end

  ////////////////////////////////////////////////////////////////////////
  // State declarations
  logic [1:0] phase_q, phase_d;         // Q1..Q4 phase counter
  rrx_state_t state_q, state_d;         // Instruction sequencer
  logic [15:0] instr_q, instr_d;        // Opcode in flight
  rrx_ctx_t ctx_q, ctx_d;               // Live W, flags, bank
  rrx_ctx_t shd_q, shd_d;               // Shadow copies
  logic [PC_W-1:0] pc_q, pc_d;          // Program counter
  logic [4:0] pcUpperLatch_q, pcUpperLatch_d;
  logic [7:0] pcHighLatch_q, pcHighLatch_d;
  logic highPrioGlobalIrqEnable_q, highPrioGlobalIrqEnable_d;
  logic lowPrioGlobalIrqEnable_q, lowPrioGlobalIrqEnable_d;
  logic lowSel_q, lowSel_d;             // Which enable a return sets
  logic [SP_W-1:0] sp_q, sp_d;          // Stack entry count
  logic illegal_q, illegal_d;           // Sticky error flags
  logic under_q, under_d;
  logic over_q, over_d;
  logic [FILE_AW-1:0] fileAddr_q, fileAddr_d;
  logic busy_d;

  // Storage; not reset, software initialises what it uses
  logic [7:0] fileMem [FILE_DEPTH];
  logic [PC_W-1:0] stackMem [STACK_DEPTH];

  // Memory write ports computed by the core process
  logic fileWe;
  logic [FA_W-1:0] fileWa;
  logic [7:0] fileWd;
  logic stkWe;
  logic [SP_W-1:0] stkWa;
  logic [PC_W-1:0] stkWd;

  // Bus answer
  logic ackD;
  logic [31:0] datD;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  // Opcode decode
  function automatic rrx_dec_t decode(input logic [15:0] op);
    rrx_dec_t d;
    d = '0;
    d.retInt = (op[15:1] == OPC_RET_INT);
    d.ret = (op[15:1] == OPC_RETURN);
    d.retLit = (op[15:8] == OPC_RET_LIT);
    d.rotate = (op[15:10] == OPC_ROT_LC);
    d.shadow = op[0] & (d.retInt | d.ret);
    d.twoCycle = d.retInt | d.ret | d.retLit;
    d.illegal = ~(d.retInt | d.ret | d.retLit | d.rotate);
    return d;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////
  // Shared combinational views
  rrx_dec_t dec;
  logic busWr;
  logic [31:0] busOld;
  logic [31:0] busVal;
  logic [PC_W-1:0] stackTop;
  logic [FILE_AW-1:0] rotAddr;
  logic rotInRange;
  logic [7:0] rotSrc;
  logic [7:0] rotRes;
  logic ptrInRange;
  logic [7:0] ptrData;

  always_comb begin
    dec = decode(instr_q);
    // A write lands on the edge where the master sees ack
    busWr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    busOld = wb_dat_o;
    busVal = merge(busOld, wb_dat_i, wb_sel_i);
    stackTop = (sp_q != '0) ? stackMem[sp_q - SP_W'(1)] : '0;
    // Access bank splits low offsets to bank 0, high to the top bank
    if (instr_q[8]) begin
      rotAddr = {ctx_q.bankSel, instr_q[7:0]};
    end else if (instr_q[7:0] < ACC_SPLIT) begin
      rotAddr = {4'h0, instr_q[7:0]};
    end else begin
      rotAddr = {ACC_HI_BANK, instr_q[7:0]};
    end
    rotInRange = ({1'b0, rotAddr} < 13'(FILE_DEPTH));
    rotSrc = rotInRange ? fileMem[rotAddr[FA_W-1:0]] : RST_BYTE;
    rotRes = {rotSrc[6:0], ctx_q.status[ST_C]};
    ptrInRange = ({1'b0, fileAddr_q} < 13'(FILE_DEPTH));
    ptrData = ptrInRange ? fileMem[fileAddr_q[FA_W-1:0]] : RST_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer: ack one cycle after the request, dropped the next cycle
  always_comb begin
    ackD = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    datD = wb_dat_o;
    // Only reads refresh the data word, so it stands until the next read
    if (ackD && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: datD = {12'h000, over_q, under_q, illegal_q,
                          execBusy_q, instr_q};
        REG_W: datD = 32'(ctx_q.w);
        REG_STATUS: datD = 32'(ctx_q.status);
        REG_BANK: datD = 32'(ctx_q.bankSel);
        REG_SHADOW: datD = 32'(shd_q);
        REG_PC: datD = 32'(pc_q);
        REG_STACK: datD = 32'(stackTop);
        REG_DEPTH: datD = 32'(sp_q);
        REG_INTCON: datD = {29'h0, lowSel_q, lowPrioGlobalIrqEnable_q,
                            highPrioGlobalIrqEnable_q};
        REG_LATCH: datD = {16'h0000, pcHighLatch_q, 3'h0, pcUpperLatch_q};
        REG_FADDR: datD = 32'(fileAddr_q);
        REG_FDATA: datD = 32'(ptrData);
        default: datD = 32'h0000_0000;   // Unmapped reads as zero
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= ackD;
      wb_dat_o <= datD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core next state: bus writes first, then execution so events win
  always_comb begin
    phase_d = phase_q + 2'h1;
    state_d = state_q;
    instr_d = instr_q;
    ctx_d = ctx_q;
    shd_d = shd_q;
    pc_d = pc_q;
    pcUpperLatch_d = pcUpperLatch_q;
    pcHighLatch_d = pcHighLatch_q;
    highPrioGlobalIrqEnable_d = highPrioGlobalIrqEnable_q;
    lowPrioGlobalIrqEnable_d = lowPrioGlobalIrqEnable_q;
    lowSel_d = lowSel_q;
    sp_d = sp_q;
    illegal_d = illegal_q;
    under_d = under_q;
    over_d = over_q;
    fileAddr_d = fileAddr_q;
    fileWe = 1'b0;
    fileWa = '0;
    fileWd = RST_BYTE;
    stkWe = 1'b0;
    stkWa = sp_q;
    stkWd = '0;

    // Software access; architectural state is frozen while busy so
    // an instruction never races a register write
    if (busWr) begin
      if (wb_adr_i == REG_CTRL) begin
        if (busVal[CTRL_CLR]) begin
          illegal_d = 1'b0;
          under_d = 1'b0;
          over_d = 1'b0;
        end
        // A new opcode is ignored while one is in flight
        if (wb_sel_i[2] && wb_dat_i[CTRL_GO] && state_q == ST_IDLE) begin
          instr_d = busVal[15:0];
          state_d = ST_WAITQ1;
        end
      end else if (state_q == ST_IDLE) begin
        case (wb_adr_i)
          REG_W: ctx_d.w = busVal[7:0];
          REG_STATUS: ctx_d.status = busVal[7:0];
          REG_BANK: ctx_d.bankSel = busVal[3:0];
          REG_SHADOW: shd_d = busVal[19:0];
          REG_PC: pc_d = busVal[PC_W-1:0];
          REG_STACK: begin
            // Push; a full stack refuses and flags overflow
            if (sp_q < SP_W'(STACK_DEPTH)) begin
              stkWe = 1'b1;
              stkWd = busVal[PC_W-1:0];
              sp_d = sp_q + SP_W'(1);
            end else begin
              over_d = 1'b1;
            end
          end
          REG_INTCON: begin
            highPrioGlobalIrqEnable_d = busVal[IC_HIGH_EN];
            lowPrioGlobalIrqEnable_d = busVal[IC_LOW_EN];
            lowSel_d = busVal[IC_LOWSEL];
          end
          REG_LATCH: begin
            pcUpperLatch_d = busVal[4:0];
            pcHighLatch_d = busVal[LAT_HI_LSB +: 8];
          end
          REG_FADDR: fileAddr_d = busVal[FILE_AW-1:0];
          REG_FDATA: begin
            fileWe = ptrInRange;
            fileWa = fileAddr_q[FA_W-1:0];
            fileWd = busVal[7:0];
          end
          default: ;   // Unmapped and read-only offsets ignore writes
        endcase
      end
    end

    // Instruction sequencer: decode in Q1, act in Q4 of the first cycle
    case (state_q)
      ST_IDLE: ;
      ST_WAITQ1: begin
        if (phase_q == PH_Q4) begin
          state_d = ST_CYC1;
        end
      end
      ST_CYC1: begin
        if (phase_q == PH_Q4) begin
          state_d = dec.twoCycle ? ST_CYC2 : ST_IDLE;
          if (dec.illegal) begin
            illegal_d = 1'b1;
          end
          // Every return pops; the latches keep their values
          if (dec.twoCycle) begin
            pc_d = stackTop;
            if (sp_q != '0) begin
              sp_d = sp_q - SP_W'(1);
            end else begin
              under_d = 1'b1;
            end
          end
          if (dec.retInt) begin
            if (lowSel_q) begin
              lowPrioGlobalIrqEnable_d = 1'b1;
            end else begin
              highPrioGlobalIrqEnable_d = 1'b1;
            end
          end
          // Shadow restore only with s set; otherwise context stands
          if (dec.shadow) begin
            ctx_d = shd_q;
          end
          if (dec.retLit) begin
            ctx_d.w = instr_q[7:0];
          end
          if (dec.rotate) begin
            ctx_d.status[ST_C] = rotSrc[7];
            ctx_d.status[ST_N] = rotRes[7];
            ctx_d.status[ST_Z] = (rotRes == RST_BYTE);
            if (instr_q[9]) begin
              fileWe = rotInRange;
              fileWa = rotAddr[FA_W-1:0];
              fileWd = rotRes;
            end else begin
              ctx_d.w = rotRes;
            end
          end
        end
      end
      ST_CYC2: begin
        // Second cycle of a return is a pure bubble
        if (phase_q == PH_Q4) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // Core registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 2'h0;
      state_q <= ST_IDLE;
      instr_q <= 16'h0000;
      ctx_q <= '0;
      shd_q <= '0;
      pc_q <= '0;
      pcUpperLatch_q <= 5'h00;
      pcHighLatch_q <= 8'h00;
      highPrioGlobalIrqEnable_q <= 1'b0;
      lowPrioGlobalIrqEnable_q <= 1'b0;
      lowSel_q <= 1'b0;
      sp_q <= '0;
      illegal_q <= 1'b0;
      under_q <= 1'b0;
      over_q <= 1'b0;
      fileAddr_q <= '0;
      execBusy_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      state_q <= state_d;
      instr_q <= instr_d;
      ctx_q <= ctx_d;
      shd_q <= shd_d;
      pc_q <= pc_d;
      pcUpperLatch_q <= pcUpperLatch_d;
      pcHighLatch_q <= pcHighLatch_d;
      highPrioGlobalIrqEnable_q <= highPrioGlobalIrqEnable_d;
      lowPrioGlobalIrqEnable_q <= lowPrioGlobalIrqEnable_d;
      lowSel_q <= lowSel_d;
      sp_q <= sp_d;
      illegal_q <= illegal_d;
      under_q <= under_d;
      over_q <= over_d;
      fileAddr_q <= fileAddr_d;
      execBusy_q <= busy_d;
    end
  end

  // Memory write ports
  always_ff @(posedge sys_clk) begin
    if (fileWe) begin
      fileMem[fileWa] <= fileWd;
    end
    if (stkWe) begin
      stackMem[stkWa] <= stkWd;
    end
  end

endmodule : rrx_exec

// file: logic/rrx_pkg.sv
// Shared constants and types for the return and rotate execution block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package rrx_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Architectural widths
  localparam int PC_W = 21;           // Program counter width
  localparam int FILE_AW = 12;        // Bank plus offset address width

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;   // Opcode issue and error flags
  localparam logic [7:0] REG_W = 8'h04;      // Working register
  localparam logic [7:0] REG_STATUS = 8'h08; // Flags register
  localparam logic [7:0] REG_BANK = 8'h0c;   // Bank select register
  localparam logic [7:0] REG_SHADOW = 8'h10; // Shadow copies
  localparam logic [7:0] REG_PC = 8'h14;     // Program counter
  localparam logic [7:0] REG_STACK = 8'h18;  // Read top, write pushes
  localparam logic [7:0] REG_DEPTH = 8'h1c;  // Stack entry count
  localparam logic [7:0] REG_INTCON = 8'h20; // Global interrupt enables
  localparam logic [7:0] REG_LATCH = 8'h24;  // Upper and high PC latches
  localparam logic [7:0] REG_FADDR = 8'h28;  // File register pointer
  localparam logic [7:0] REG_FDATA = 8'h2c;  // File register data

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_GO = 16;        // Write: issue opcode in [15:0]
  localparam int CTRL_CLR = 17;       // Write: clear error flags
  localparam int CTRL_BUSY = 16;      // Read: instruction in flight
  localparam int CTRL_ILL = 17;       // Read: unknown opcode seen
  localparam int CTRL_UNF = 18;       // Read: pop from empty stack
  localparam int CTRL_OVF = 19;       // Read: push onto full stack
  localparam int ST_C = 0;            // Carry flag
  localparam int ST_Z = 2;            // Zero flag
  localparam int ST_N = 4;            // Negative flag
  localparam int IC_HIGH_EN = 0;      // High priority global enable
  localparam int IC_LOW_EN = 1;       // Low priority global enable
  localparam int IC_LOWSEL = 2;       // Return re-enables low priority
  localparam int LAT_HI_LSB = 8;      // High latch sits in [15:8]

  ////////////////////////////////////////////////////////////////////////
  // Opcode patterns
  localparam logic [7:0] OPC_RET_LIT = 8'h0c;     // Upper byte of literal return
  localparam logic [14:0] OPC_RET_INT = 15'h0008; // 0000 0000 0001 000s
  localparam logic [14:0] OPC_RETURN = 15'h0009;  // 0000 0000 0001 001s
  localparam logic [5:0] OPC_ROT_LC = 6'h0d;      // 0011 01da ffff ffff

  ////////////////////////////////////////////////////////////////////////
  // Phases, banks and reset values
  localparam logic [1:0] PH_Q4 = 2'h3;         // Last phase of a cycle
  localparam logic [7:0] ACC_SPLIT = 8'h80;    // Access bank split point
  localparam logic [3:0] ACC_HI_BANK = 4'hf;   // Upper half of access bank
  localparam logic [7:0] RST_BYTE = 8'h00;     // Reset of data registers

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [3:0] bankSel;
    logic [7:0] status;
    logic [7:0] w;
  } rrx_ctx_t;

  typedef struct packed {
    logic retInt;
    logic retLit;
    logic ret;
    logic rotate;
    logic shadow;
    logic twoCycle;
    logic illegal;
  } rrx_dec_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAITQ1 = 4'b0010,
    ST_CYC1 = 4'b0100,
    ST_CYC2 = 4'b1000
  } rrx_state_t;

endpackage : rrx_pkg

// file: verification/rrx_exec_sva.sv
// Checker for the return and rotate block: bus handshake and busy timing.
// Assumes it is bound into rrx_exec and sees only the top-level ports.
`timescale 1ns/1ps

module rrx_exec_sva
  import rrx_pkg::*;
#(
  parameter int STACK_DEPTH = 31,
  parameter int FILE_BANKS = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Status
  input wire logic execBusy_q
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  wire logic reqOpen = wb_cyc_i && wb_stb_i && !wb_ack_o; // Request awaiting answer
  wire logic goWrite = wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL && wb_dat_i[CTRL_GO];

  // Accepted issue: busy must be low, or the go is ignored
  sequence s_issue;
    goWrite && wb_sel_i[2] && !execBusy_q;
  endsequence
  // Shortest one-cycle op holds busy five clocks, longest return twelve; the window allows four to fifteen
  sequence s_run;
    execBusy_q [*4] ##[1:12] !execBusy_q;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_ack_follows_req: assert property (reqOpen |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_read_data_holds: assert property (!$stable(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data changed outside a read answer");
  a_issue_sets_busy: assert property (s_issue |=> execBusy_q)
    else $error("accepted issue did not raise busy");
  a_busy_has_cause: assert property ($rose(execBusy_q) |-> $past(goWrite))
    else $error("busy rose without an issue write");
  a_busy_bounded_run: assert property ($rose(execBusy_q) |-> s_run)
    else $error("instruction length outside its cycle count");
  a_unmapped_reads_zero: assert property (
    reqOpen && !wb_we_i && wb_adr_i >= 8'h30 |=> wb_dat_o == 32'h0)
    else $error("unmapped read returned nonzero");

endmodule : rrx_exec_sva

bind rrx_exec rrx_exec_sva #(.STACK_DEPTH(STACK_DEPTH), .FILE_BANKS(FILE_BANKS)) rrx_exec_sva_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .execBusy_q(execBusy_q));

// file: verification/tb_top.sv
// Self-checking bench for the return and rotate block, with a register model.
// Assumes the designer's register map and one-cycle Wishbone answer.
`timescale 1ns/1ps

module tb_top
  import rrx_pkg::*;
();

  ////////////////////////////////////////////////////////////////////////
  // Design hookup
  logic sys_clk, rst_b, wbCyc, wbStb, wbWe, wbAck, execBusy;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h84b2; // LFSR state
  logic [31:0] r, rd, op;
  logic [7:0] mW, mSt, fo, v, res; // Model of W, flags and rotate operands
  logic [3:0] mBsr, bank;
  logic [19:0] mSh;
  logic [2:0] mIc;
  logic [31:0] mLat;
  logic [20:0] top;
  logic [15:0] retOps [5] = '{16'h0012, 16'h0013, 16'h0010, 16'h0011, 16'h0c00};

  rrx_exec rrx_exec_i (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .execBusy_q(execBusy));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // A wait that ran dry counts as a mismatch and ends the run
  task automatic hang();
    n_fail++;
    $display("ERROR t=%0t timeout exp %h got %h", $time, 1'b1, 1'b0);
    report_and_stop();
  endtask : hang

  function automatic logic [31:0] rnd();
    seed = {1'b0, seed[31:1]} ^ (seed[0] ? 32'h80200003 : 32'h0);
    return seed;
  endfunction : rnd

  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    wbSel <= 4'hf;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1) begin
      hang();
    end
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    bus(1'b1, adr, dat, q);
  endtask : wr

  // Register word compare against the model
  task automatic chk_reg(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, adr, 32'h0, q);
    n_checks++;
    if (q !== exp) begin
      n_fail++;
      $display("ERROR t=%0t adr %h exp %h got %h", $time, adr, exp, q);
    end
  endtask : chk_reg

  // Issue one opcode, then poll busy so the next issue is never dropped
  task automatic exec(input logic [15:0] o);
    int n;
    wr(REG_CTRL, {15'h0, 1'b1, o});
    n = 0;
    do begin
      bus(1'b0, REG_CTRL, 32'h0, rd);
      n++;
    end while (rd[CTRL_BUSY] !== 1'b0 && n < 40);
    if (rd[CTRL_BUSY] !== 1'b0) begin
      hang();
    end
  endtask : exec

  // Load the whole visible context from the model
  task automatic load_ctx();
    wr(REG_W, {24'h0, mW});
    wr(REG_STATUS, {24'h0, mSt});
    wr(REG_BANK, {28'h0, mBsr});
  endtask : load_ctx

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = '0;
    rst_b = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Reset values and an unmapped place
    chk_reg(REG_W, 32'h0);
    chk_reg(REG_PC, 32'h0);
    chk_reg(REG_DEPTH, 32'h0);
    wr(8'h30, 32'hffffffff);
    chk_reg(8'h30, 32'h0);
    $display("test reset done");
    // Every return form, twice, with random context
    for (int k = 0; k < 10; k++) begin
      r = rnd();
      {mIc, mBsr, mSt, mW} = {r[20], 2'b00, r[19:0]};
      r = rnd();
      mSh = r[19:0];
      r = rnd();
      top = r[20:0];
      mLat = {16'h0, r[31:24], 3'h0, r[25:21]};
      op = {16'h0, retOps[k % 5]};
      if (op[15:8] == OPC_RET_LIT) begin
        op[7:0] = r[31:24];
      end
      load_ctx();
      wr(REG_SHADOW, {12'h0, mSh});
      wr(REG_INTCON, {29'h0, mIc});
      wr(REG_LATCH, mLat);
      wr(REG_STACK, {11'h0, top});
      exec(op[15:0]);
      if (op[15:8] == OPC_RET_LIT) begin
        mW = op[7:0];
      end else if (op[0]) begin
        {mBsr, mSt, mW} = mSh;
      end
      if (op[15:1] == OPC_RET_INT) begin
        mIc = mIc | (mIc[IC_LOWSEL] ? 3'h2 : 3'h1);
      end
      chk_reg(REG_PC, {11'h0, top});
      chk_reg(REG_W, {24'h0, mW});
      chk_reg(REG_STATUS, {24'h0, mSt});
      chk_reg(REG_BANK, {28'h0, mBsr});
      chk_reg(REG_INTCON, {29'h0, mIc});
      chk_reg(REG_LATCH, mLat);
      chk_reg(REG_DEPTH, 32'h0);
    end
    $display("test returns done");
    // Rotate with both destinations, both bank choices and the split edges
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      {mSt, v, mBsr, op[9:8], fo} = r[29:0];
      r = rnd();
      mW = r[7:0];
      if (k < 2) begin
        {fo, op[8]} = {8'h7f + k[7:0], 1'b0};
      end
      if (k == 2) begin
        {v, mSt[ST_C]} = 9'h100;
      end
      bank = op[8] ? mBsr : (fo < ACC_SPLIT ? 4'h0 : ACC_HI_BANK);
      load_ctx();
      wr(REG_FADDR, {20'h0, bank, fo});
      wr(REG_FDATA, {24'h0, v});
      exec({OPC_ROT_LC, op[9:8], fo});
      res = {v[6:0], mSt[ST_C]};
      mSt[ST_C] = v[7];
      mSt[ST_N] = res[7];
      mSt[ST_Z] = (res == 8'h0);
      if (!op[9]) begin
        mW = res;
      end
      chk_reg(REG_W, {24'h0, mW});
      chk_reg(REG_STATUS, {24'h0, mSt});
      chk_reg(REG_FDATA, {24'h0, op[9] ? res : v});
    end
    $display("test rotate done");
    // Unknown opcode, then a return from an empty stack
    for (int k = 0; k < 2; k++) begin
      op = k ? 32'h0012 : 32'h0007;
      wr(REG_CTRL, 32'h1 << CTRL_CLR);
      wr(REG_PC, 32'h0000_1234);
      exec(op[15:0]);
      chk_reg(REG_CTRL, (32'h1 << (k ? CTRL_UNF : CTRL_ILL)) | op);
      chk_reg(REG_PC, k ? 32'h0 : 32'h0000_1234);
    end
    $display("test errors done");
    report_and_stop();
  end

endmodule : tb_top
